// File: hdl/rx_out_port_cfg.svh
// Constants for the receive parallel output port
`ifndef RX_OUT_PORT_CFG_SVH
`define RX_OUT_PORT_CFG_SVH

`define RXP_ADDR_W        8
`define RXP_OFF_CTRL      8'h00
`define RXP_OFF_STATUS    8'h04
`define RXP_OFF_MASK      8'h08
`define RXP_OFF_INFO      8'h0c

`define RXP_CTRL_RESET    1'b1
`define RXP_CTRL_DRV_EN   0
`define RXP_MASK_RESET    3'h0

`define RXP_EV_W          3
`define RXP_EV_CHAR       0
`define RXP_EV_COMMA      1
`define RXP_EV_REFRAME    2

`define RXP_INFO_DATA_LSB 0
`define RXP_INFO_ST_LSB   8
`define RXP_INFO_PAR      11
`define RXP_INFO_REFMODE  12
`define RXP_INFO_DECODER  13
`define RXP_INFO_HALF     14
`define RXP_INFO_PAR_EN   15
`define RXP_INFO_FRAMER   16

`define RXP_TERN_LOW      2'b00
`define RXP_TERN_HIGH     2'b10

`define RXP_COMMA_POS     7'h1f
`define RXP_COMMA_NEG     7'h60

`endif

// File: hdl/rx_out_port_pkg.sv
// Types for the receive parallel output port
package rx_out_port_pkg;
	typedef enum logic [1:0] {
		TERN_LOW,
		TERN_MID,
		TERN_HIGH
	} tern_t;
endpackage : rx_out_port_pkg

// File: hdl/rx_out_port.sv
// Receive parallel output port with AHB-Lite control and interrupt
//
// Contract
// [RULE_01] Status outputs change only after a rising edge of the selected clock.
// [RULE_02] Decoder bypassed: status bits 1..0 carry raw character bits 1..0.
// [RULE_03] Decoder bypassed: status bit 2 flags a comma in the output register.
// [RULE_04] Decoder enabled: status outputs carry received character status.
// [RULE_05] Parity control not low: parity output is odd parity over output bits.
// [RULE_06] Parity control low: parity output driver is released.
// [RULE_07] Clock select mid: true and complement recovered clocks time all outputs.
// [RULE_08] Recovered mode: output clock at character or dual-character rate by rate select.
// [RULE_09] Clock select low: output clock pair is a delayed copy of reference clock.
// [RULE_10] Delayed reference output enabled only in reference mode, slightly later.
// [RULE_11] Rate low: clocks at character rate; host latches on true rising edge.
// [RULE_12] Rate high: clocks at half rate; host latches alternately on both rises.
// [RULE_13] Reference mode ignores rate select; output clock follows reference clock.
// [RULE_14] Reframe enable high lets the framer realign character boundaries.
// [RULE_15] Status mode picks one of two schemes, used only with decoder enabled.
// [RULE_16] Ternary inputs decode low, mid, high; unconnected reads as mid.
// [RULE_17] Decoder bypassed: data outputs carry the eight upper raw bits.
// [RULE_18] Data, status and parity of one character change on the same edge.
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "rx_out_port_cfg.svh"

module rx_out_port #(
	parameter int PERIOD_W = 16
) (
	input  wire logic        CORE_CLK_I,             // Core clock, 100 MHz
	input  wire logic        RST_I,                  // Synchronous reset, active high
	input  wire logic        HSEL_I,                 // AHB slave select
	input  wire logic [31:0] HADDR_I,                // AHB address
	input  wire logic [1:0]  HTRANS_I,               // AHB transfer type
	input  wire logic        HWRITE_I,               // AHB write
	input  wire logic [2:0]  HSIZE_I,                // AHB size
	input  wire logic [31:0] HWDATA_I,               // AHB write data
	input  wire logic        HREADY_I,               // AHB bus ready
	output logic      [31:0] HRDATA_O,               // AHB read data
	output logic             HREADYOUT_O,            // AHB slave ready
	output logic             HRESP_O,                // AHB response, always OKAY
	output logic             IRQ_O,                  // Interrupt, level high
	input  wire logic        CHAR_VALID_I,           // New character from framer/decoder
	input  wire logic [9:0]  RAW_CHAR_I,             // Raw framed character
	input  wire logic [7:0]  DEC_DATA_I,             // Decoded character
	input  wire logic [2:0]  DEC_STATUS_A_I,         // Status, first scheme
	input  wire logic [2:0]  DEC_STATUS_B_I,         // Status, second scheme
	input  wire logic        REFERENCE_CLOCK_I,      // Reference clock pin
	input  wire logic        RX_CLOCK_RATE_SEL_I,    // Rate select pin
	input  wire logic        REFRAME_ENABLE_I,       // Reframe enable pin, async
	input  wire logic [1:0]  RX_STATUS_MODE_SEL_I,   // Ternary status mode select
	input  wire logic [1:0]  RX_CLOCK_SOURCE_SEL_I,  // Ternary clock source select
	input  wire logic [1:0]  DECODER_MODE_SEL_I,     // Ternary decoder mode
	input  wire logic [1:0]  PARITY_CONTROL_I,       // Ternary parity control
	output logic      [7:0]  RX_DATA_OUT_O,          // Parallel data
	output logic      [2:0]  RX_STATUS_OUT_O,        // Parallel status
	output logic             RX_DATA_OE_O,           // Data and status drive enable
	output logic             RX_ODD_PARITY_OUT_O,    // Odd parity
	output logic             RX_ODD_PARITY_OUT_OE_O, // Parity drive enable
	output logic             RX_CHAR_CLOCK_OUT_P_O,  // True character clock
	output logic             RX_CHAR_CLOCK_OUT_N_O,  // Complement character clock
	output logic             RX_CHAR_CLOCK_OUT_OE_O, // Character clock drive enable
	output logic             RX_DELAYED_REFERENCE_CLOCK_OUT_O,    // Delayed reference clock
	output logic             RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O, // Its drive enable
	output logic             FRAMER_ENABLE_O         // Framer realign permission
);

	// Pin synchronisers; first stage is read only by the second
	logic [11:0] pin_s1;
	logic [11:0] pin_s2;
	logic        ref_s3;
	logic        reframe_s3;

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			pin_s1 <= 12'h000;
			pin_s2 <= 12'h000;
		end
		else
		begin
			pin_s1 <= {PARITY_CONTROL_I, DECODER_MODE_SEL_I, RX_CLOCK_SOURCE_SEL_I,
				RX_STATUS_MODE_SEL_I, REFRAME_ENABLE_I, RX_CLOCK_RATE_SEL_I,
				REFERENCE_CLOCK_I, 1'b1};
			pin_s2 <= pin_s1;
		end
	end

	wire logic ref_sync     = pin_s2[1];
	wire logic rate_half    = pin_s2[2];
	wire logic reframe_sync = pin_s2[3];
	// Bit 0 marks the pipe as filled; until then the reset codes read as low
	wire logic cfg_ready    = pin_s2[0];

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			ref_s3     <= 1'b0;
			reframe_s3 <= 1'b0;
		end
		else
		begin
			ref_s3     <= ref_sync;
			reframe_s3 <= reframe_sync;
		end
	end

	wire logic ref_rise     = ref_sync & ~ref_s3;
	wire logic reframe_rise = reframe_sync & ~reframe_s3;

	// [RULE_16] ternary pin decode
	function automatic rx_out_port_pkg::tern_t tern_decode(input logic [1:0] code);
		if (code == `RXP_TERN_LOW)
			return rx_out_port_pkg::TERN_LOW;
		else if (code == `RXP_TERN_HIGH)
			return rx_out_port_pkg::TERN_HIGH;
		else
			return rx_out_port_pkg::TERN_MID;
	endfunction : tern_decode

	rx_out_port_pkg::tern_t status_mode;
	rx_out_port_pkg::tern_t clock_source;
	rx_out_port_pkg::tern_t decoder_mode;
	rx_out_port_pkg::tern_t parity_mode;

	always_comb
	begin
		status_mode  = tern_decode(pin_s2[5:4]);
		clock_source = tern_decode(pin_s2[7:6]);
		decoder_mode = tern_decode(pin_s2[9:8]);
		parity_mode  = tern_decode(pin_s2[11:10]);
	end

	wire logic ref_mode    = (clock_source == rx_out_port_pkg::TERN_LOW);
	wire logic dec_enabled = (decoder_mode != rx_out_port_pkg::TERN_LOW);
	wire logic par_enabled = (parity_mode != rx_out_port_pkg::TERN_LOW);

	// Holding stage: one character, overwritten if the reference clock is slower
	logic [9:0] pend_raw;
	logic [7:0] pend_data;
	logic [2:0] pend_st_a;
	logic [2:0] pend_st_b;
	logic       pend_fresh;

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			pend_raw   <= 10'h000;
			pend_data  <= 8'h00;
			pend_st_a  <= 3'h0;
			pend_st_b  <= 3'h0;
			pend_fresh <= 1'b0;
		end
		else
		begin
			pend_fresh <= CHAR_VALID_I;
			if (CHAR_VALID_I)
			begin
				pend_raw  <= RAW_CHAR_I;
				pend_data <= DEC_DATA_I;
				pend_st_a <= DEC_STATUS_A_I;
				pend_st_b <= DEC_STATUS_B_I;
			end
		end
	end

	// Output field formation
	logic [7:0] next_data;
	logic [2:0] next_status;
	logic       next_parity;
	logic       next_comma;

	always_comb
	begin
		next_comma = (pend_raw[9:3] == `RXP_COMMA_POS) || (pend_raw[9:3] == `RXP_COMMA_NEG);
		if (dec_enabled)
		begin
			next_data = pend_data;
			// [RULE_04] [RULE_15] status scheme select
			if (status_mode == rx_out_port_pkg::TERN_HIGH)
				next_status = pend_st_b;
			else
				next_status = pend_st_a;
			// [RULE_05] parity over data
			next_parity = ~(^pend_data);
		end
		else
		begin
			// [RULE_17] upper raw bits
			next_data = pend_raw[9:2];
			// [RULE_02] [RULE_03] raw low bits and comma flag
			next_status = {next_comma, pend_raw[1:0]};
			// [RULE_05] parity over data and low status
			next_parity = ~(^{pend_raw[9:2], pend_raw[1:0]});
		end
	end

	// [RULE_01] [RULE_13] load on recovered character or reference rise only
	wire logic load_now = ref_mode ? ref_rise : pend_fresh;

	logic events_comma;

	// [RULE_18] one register for data, status and parity
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			RX_DATA_OUT_O       <= 8'h00;
			RX_STATUS_OUT_O     <= 3'h0;
			RX_ODD_PARITY_OUT_O <= 1'b1;
			events_comma        <= 1'b0;
		end
		else
		begin
			events_comma <= 1'b0;
			if (load_now)
			begin
				RX_DATA_OUT_O       <= next_data;
				RX_STATUS_OUT_O     <= next_status;
				RX_ODD_PARITY_OUT_O <= next_parity;
				events_comma        <= next_comma;
			end
		end
	end

	// Character period measure; the fall lands midway between characters
	logic [PERIOD_W-1:0] since_char;
	logic [PERIOD_W-1:0] last_period;

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			since_char  <= '0;
			last_period <= '0;
		end
		else if (pend_fresh)
		begin
			since_char  <= PERIOD_W'(1);
			last_period <= since_char;
		end
		else if (since_char != '1)
			since_char <= since_char + PERIOD_W'(1);
	end

	wire logic half_point = (since_char == (last_period >> 1)) || (last_period < PERIOD_W'(2));

	logic rec_clk;

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			rec_clk <= 1'b0;
		// [RULE_12] half rate: one toggle per character
		else if (rate_half)
		begin
			if (pend_fresh)
				rec_clk <= ~rec_clk;
		end
		// [RULE_08] [RULE_11] character rate: rise per character, fall at half
		else if (pend_fresh)
			rec_clk <= 1'b1;
		else if (half_point)
			rec_clk <= 1'b0;
	end

	logic drv_en;

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			RX_CHAR_CLOCK_OUT_P_O      <= 1'b0;
			RX_CHAR_CLOCK_OUT_N_O      <= 1'b1;
			RX_CHAR_CLOCK_OUT_OE_O     <= 1'b0;
			RX_DELAYED_REFERENCE_CLOCK_OUT_O    <= 1'b0;
			RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O <= 1'b0;
			RX_DATA_OE_O               <= 1'b0;
			RX_ODD_PARITY_OUT_OE_O     <= 1'b0;
		end
		else
		begin
			// [RULE_09] [RULE_13] reference copy, else [RULE_07] recovered pair
			RX_CHAR_CLOCK_OUT_P_O  <= ref_mode ? ref_sync : rec_clk;
			RX_CHAR_CLOCK_OUT_N_O  <= ref_mode ? ~ref_sync : ~rec_clk;
			RX_CHAR_CLOCK_OUT_OE_O <= drv_en;
			// [RULE_10] one stage later, only in reference mode
			RX_DELAYED_REFERENCE_CLOCK_OUT_O    <= ref_mode & ref_s3;
			// Mode-dependent enables wait for the pins, so no pulse after reset
			RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O <= drv_en & ref_mode & cfg_ready;
			RX_DATA_OE_O               <= drv_en;
			// [RULE_06] parity driver released when disabled
			RX_ODD_PARITY_OUT_OE_O     <= drv_en & par_enabled & cfg_ready;
		end
	end

	// [RULE_14] reframe permission after synchronising
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			FRAMER_ENABLE_O <= 1'b0;
		else
			FRAMER_ENABLE_O <= reframe_sync;
	end

	// AHB-Lite slave, zero wait states
	wire logic addr_phase = HSEL_I & HTRANS_I[1] & HREADY_I;
	wire logic [`RXP_ADDR_W-1:0] addr_lo = HADDR_I[`RXP_ADDR_W-1:0];

	logic                   wr_pend;
	logic [`RXP_ADDR_W-1:0] wr_addr;
	logic [`RXP_EV_W-1:0]   ev_status;
	logic [`RXP_EV_W-1:0]   ev_mask;
	logic [31:0]            info_word;

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end
		else
		begin
			wr_pend <= addr_phase & HWRITE_I;
			if (addr_phase)
				wr_addr <= addr_lo;
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			drv_en  <= `RXP_CTRL_RESET;
			ev_mask <= `RXP_MASK_RESET;
		end
		else if (wr_pend)
		begin
			if (wr_addr == `RXP_OFF_CTRL)
				drv_en <= HWDATA_I[`RXP_CTRL_DRV_EN];
			else if (wr_addr == `RXP_OFF_MASK)
				ev_mask <= HWDATA_I[`RXP_EV_W-1:0];
		end
	end

	always_comb
	begin
		info_word = 32'h0000_0000;
		info_word[`RXP_INFO_DATA_LSB +: 8] = RX_DATA_OUT_O;
		info_word[`RXP_INFO_ST_LSB +: 3]   = RX_STATUS_OUT_O;
		info_word[`RXP_INFO_PAR]           = RX_ODD_PARITY_OUT_O;
		info_word[`RXP_INFO_REFMODE]       = ref_mode;
		info_word[`RXP_INFO_DECODER]       = dec_enabled;
		info_word[`RXP_INFO_HALF]          = rate_half;
		info_word[`RXP_INFO_PAR_EN]        = par_enabled;
		info_word[`RXP_INFO_FRAMER]        = FRAMER_ENABLE_O;
	end

	wire logic status_read = addr_phase & ~HWRITE_I & (addr_lo == `RXP_OFF_STATUS);

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			HRDATA_O <= 32'h0000_0000;
		else if (addr_phase & ~HWRITE_I)
		begin
			if (addr_lo == `RXP_OFF_CTRL)
				HRDATA_O <= {31'h0000_0000, drv_en};
			else if (addr_lo == `RXP_OFF_STATUS)
				HRDATA_O <= {29'h0000_0000, ev_status};
			else if (addr_lo == `RXP_OFF_MASK)
				HRDATA_O <= {29'h0000_0000, ev_mask};
			else if (addr_lo == `RXP_OFF_INFO)
				HRDATA_O <= info_word;
			else
				HRDATA_O <= 32'h0000_0000;
		end
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			HREADYOUT_O <= 1'b0;
			HRESP_O     <= 1'b0;
		end
		else
		begin
			HREADYOUT_O <= 1'b1;
			HRESP_O     <= 1'b0;
		end
	end

	// Sticky events; a new event wins over the read clear
	logic [`RXP_EV_W-1:0] ev_set;

	always_comb
	begin
		ev_set = '0;
		ev_set[`RXP_EV_CHAR]    = load_now;
		ev_set[`RXP_EV_COMMA]   = events_comma;
		ev_set[`RXP_EV_REFRAME] = reframe_rise;
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			ev_status <= '0;
		else if (status_read)
			ev_status <= ev_set;
		else
			ev_status <= ev_status | ev_set;
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(ev_status & ev_mask);
	end

endmodule : rx_out_port

// File: verification/rx_out_port_chk.sv
// Pin-level assertions for the receive parallel output port
`timescale 1ns/1ps
`include "rx_out_port_cfg.svh"

module rx_out_port_chk (
	input wire logic       CORE_CLK_I,                 // Clock
	input wire logic       RST_I,                      // Reset
	input wire logic       REFERENCE_CLOCK_I,          // Ref pin
	input wire logic       REFRAME_ENABLE_I,           // Reframe pin
	input wire logic [1:0] RX_CLOCK_SOURCE_SEL_I,      // Source
	input wire logic [1:0] DECODER_MODE_SEL_I,         // Decoder
	input wire logic [1:0] PARITY_CONTROL_I,           // Parity mode
	input wire logic [7:0] RX_DATA_OUT_O,              // Data
	input wire logic [2:0] RX_STATUS_OUT_O,            // Status
	input wire logic       RX_ODD_PARITY_OUT_O,        // Parity
	input wire logic       RX_ODD_PARITY_OUT_OE_O,     // Parity drive
	input wire logic       RX_CHAR_CLOCK_OUT_P_O,      // True clock
	input wire logic       RX_CHAR_CLOCK_OUT_N_O,      // Complement
	input wire logic       RX_DELAYED_REFERENCE_CLOCK_OUT_O,    // Delayed ref
	input wire logic       RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O, // Its drive
	input wire logic       FRAMER_ENABLE_O             // Framer
);
	logic [2:0] up;
	logic       ok;
	logic       byp;

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RST_I);

	// Config pins pass synchronisers, so mode checks wait a few cycles
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			up <= 3'h0;
		else if (up != 3'h7)
			up <= up + 3'h1;
	end
	assign ok = (up == 3'h7);
	assign byp = (DECODER_MODE_SEL_I == `RXP_TERN_LOW);

	clk_pair_a: assert property (RX_CHAR_CLOCK_OUT_N_O == !RX_CHAR_CLOCK_OUT_P_O)
		else $error("clock pair not complementary");
	load_clk_a: assert property
		(!$stable({RX_DATA_OUT_O, RX_STATUS_OUT_O, RX_ODD_PARITY_OUT_O})
		|-> ##[0:1] $changed(RX_CHAR_CLOCK_OUT_P_O))
		else $error("outputs changed without a clock edge");
	par_odd_a: assert property (ok && RX_ODD_PARITY_OUT_OE_O |->
		^{RX_DATA_OUT_O, byp ? RX_STATUS_OUT_O[1:0] : 2'h0, RX_ODD_PARITY_OUT_O})
		else $error("parity not odd");
	par_off_a: assert property (ok && PARITY_CONTROL_I == `RXP_TERN_LOW
		|-> !RX_ODD_PARITY_OUT_OE_O)
		else $error("parity driven while disabled");
	comma_flag_a: assert property (ok && byp |-> RX_STATUS_OUT_O[2] ==
		(RX_DATA_OUT_O[7:1] == `RXP_COMMA_POS || RX_DATA_OUT_O[7:1] == `RXP_COMMA_NEG))
		else $error("comma flag wrong");
	ref_only_a: assert property (ok && RX_CLOCK_SOURCE_SEL_I != `RXP_TERN_LOW
		|-> !RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O && !RX_DELAYED_REFERENCE_CLOCK_OUT_O)
		else $error("delayed ref active outside ref mode");
	ref_lag_a: assert property (ok && RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O
		&& $past(RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O)
		|-> RX_DELAYED_REFERENCE_CLOCK_OUT_O == $past(RX_CHAR_CLOCK_OUT_P_O))
		else $error("delayed ref not one cycle behind");
	ref_follow_a: assert property (ok && RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O
		&& $rose(REFERENCE_CLOCK_I) |-> ##[2:4] $rose(RX_CHAR_CLOCK_OUT_P_O))
		else $error("clock not following ref");
	framer_on_a: assert property ($rose(REFRAME_ENABLE_I) |-> ##[2:4] FRAMER_ENABLE_O)
		else $error("framer not enabled");
	framer_off_a: assert property ($fell(REFRAME_ENABLE_I) |-> ##[2:4] !FRAMER_ENABLE_O)
		else $error("framer not disabled");

	cover property ($rose(RX_CHAR_CLOCK_OUT_P_O));
	cover property (RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O && $rose(RX_DELAYED_REFERENCE_CLOCK_OUT_O));
	cover property (RX_STATUS_OUT_O[2]);
	cover property ($rose(FRAMER_ENABLE_O));
endmodule : rx_out_port_chk

bind rx_out_port rx_out_port_chk u_rx_out_port_chk (.*);

// File: verification/rx_host_model.sv
// Host latch capturing characters on the output clock edges
`timescale 1ns/1ps

module rx_host_model (
	input wire logic       half_i,   // Half rate capture
	input wire logic       clk_p_i,  // True clock
	input wire logic       clk_n_i,  // Complement clock
	input wire logic [7:0] data_i,   // Data pins
	input wire logic [2:0] status_i, // Status pins
	input wire logic       par_i,    // Parity pin
	output logic     [11:0] word_o,  // Parity, status, data
	output int             count_o   // Captures made
);
	initial count_o = 0;

	// latch on true rise
	// Latch just after the edge: in reference mode register and clock move together
	always @(posedge clk_p_i)
	begin
		#1;
		word_o <= {par_i, status_i, data_i};
		count_o <= count_o + 1;
	end

	always @(posedge clk_n_i)
	begin
		#1;
		if (half_i)
		begin
			word_o <= {par_i, status_i, data_i};
			count_o <= count_o + 1;
		end
	end
endmodule : rx_host_model

// File: verification/rx_out_port_tb.sv
// Self-checking bench for the receive parallel output port
`timescale 1ns/1ps
`include "rx_out_port_cfg.svh"

module rx_out_port_tb;
	localparam logic [1:0] LO = `RXP_TERN_LOW;
	localparam logic [1:0] HI = `RXP_TERN_HIGH;
	logic        CORE_CLK_I = 1'h0;
	logic        RST_I = 1'h1;
	logic        HSEL_I = 1'h0;
	logic        HWRITE_I = 1'h0;
	logic [31:0] HADDR_I = 32'h0;
	logic [31:0] HWDATA_I = 32'h0;
	logic [1:0]  HTRANS_I = 2'h0;
	logic [2:0]  HSIZE_I = 3'h2;
	logic        CHAR_VALID_I = 1'h0;
	logic [9:0]  RAW_CHAR_I = 10'h0;
	logic [7:0]  DEC_DATA_I = 8'h0;
	logic [2:0]  DEC_STATUS_A_I = 3'h0;
	logic [2:0]  DEC_STATUS_B_I = 3'h0;
	logic        REFERENCE_CLOCK_I = 1'h0;
	logic        RX_CLOCK_RATE_SEL_I = 1'h0;
	logic        REFRAME_ENABLE_I = 1'h0;
	logic [1:0]  RX_STATUS_MODE_SEL_I = 2'h3;
	logic [1:0]  RX_CLOCK_SOURCE_SEL_I = 2'h3;
	logic [1:0]  DECODER_MODE_SEL_I = 2'h0;
	logic [1:0]  PARITY_CONTROL_I = 2'h1;
	wire logic   HREADY_I;
	logic [31:0] HRDATA_O;
	logic [7:0]  RX_DATA_OUT_O;
	logic [2:0]  RX_STATUS_OUT_O;
	logic        HREADYOUT_O, HRESP_O, IRQ_O, RX_DATA_OE_O, RX_ODD_PARITY_OUT_O;
	logic        RX_ODD_PARITY_OUT_OE_O, RX_CHAR_CLOCK_OUT_P_O, RX_CHAR_CLOCK_OUT_N_O;
	logic        RX_CHAR_CLOCK_OUT_OE_O, RX_DELAYED_REFERENCE_CLOCK_OUT_O, RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O;
	logic        FRAMER_ENABLE_O;
	logic [11:0] word;
	logic [31:0] rd;
	int          cnt;
	int          fail_count = 0;
	int          n_tests = 0;

	assign HREADY_I = HREADYOUT_O;
	always #5 CORE_CLK_I = ~CORE_CLK_I;
	// Free-running link clock, edges fall on core falling edges, between core rising edges
	always #40 REFERENCE_CLOCK_I = ~REFERENCE_CLOCK_I;

	rx_out_port u_rx_out_port (.*);

	rx_host_model u_rx_host_model (
		.half_i   (RX_CLOCK_RATE_SEL_I && (RX_CLOCK_SOURCE_SEL_I != LO)),
		.clk_p_i  (RX_CHAR_CLOCK_OUT_P_O),
		.clk_n_i  (RX_CHAR_CLOCK_OUT_N_O),
		.data_i   (RX_DATA_OUT_O),
		.status_i (RX_STATUS_OUT_O),
		.par_i    (RX_ODD_PARITY_OUT_O),
		.word_o   (word),
		.count_o  (cnt)
	);

	task automatic tally_and_finish;
		if (fail_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic hang;
		chk(32'h0, 32'h1);
		tally_and_finish();
	endtask : hang

	task automatic step_rdy;
		int n;
		n = 0;
		do
		begin
			@(posedge CORE_CLK_I);
			n++;
		end
		while (HREADY_I !== 1'h1 && n < 50);
		if (HREADY_I !== 1'h1)
			hang();
	endtask : step_rdy

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge CORE_CLK_I);
		HSEL_I <= 1'h1;
		HTRANS_I <= 2'h2;
		HWRITE_I <= w;
		HADDR_I <= {24'h0, a};
		step_rdy();
		HSEL_I <= 1'h0;
		HTRANS_I <= 2'h0;
		HWDATA_I <= wd;
		step_rdy();
		rd = HRDATA_O;
	endtask : bus

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(rd, exp);
		chk(HRESP_O, 1'h0);
	endtask : rchk

	task automatic setup(input logic [1:0] d, p, s, m, input logic r);
		@(posedge CORE_CLK_I);
		RST_I <= 1'h1;
		DECODER_MODE_SEL_I <= d;
		PARITY_CONTROL_I <= p;
		RX_CLOCK_SOURCE_SEL_I <= s;
		RX_STATUS_MODE_SEL_I <= m;
		RX_CLOCK_RATE_SEL_I <= r;
		repeat (4) @(posedge CORE_CLK_I);
		RST_I <= 1'h0;
		repeat (8) @(posedge CORE_CLK_I);
	endtask : setup

	// Waits for k host captures; ref mode needs two to be sure of the new one
	task automatic send(input logic [9:0] r, input logic [7:0] d, input logic [11:0] exp,
			input int k);
		int c;
		int n;
		c = cnt;
		n = 0;
		@(posedge CORE_CLK_I);
		CHAR_VALID_I <= 1'h1;
		RAW_CHAR_I <= r;
		DEC_DATA_I <= d;
		DEC_STATUS_A_I <= 3'h2;
		DEC_STATUS_B_I <= 3'h5;
		@(posedge CORE_CLK_I);
		CHAR_VALID_I <= 1'h0;
		while (cnt < c + k && n < 100)
		begin
			@(posedge CORE_CLK_I);
			n++;
		end
		if (cnt < c + k)
			hang();
		chk({20'h0, word}, {20'h0, exp});
		repeat (20) @(posedge CORE_CLK_I);
	endtask : send

	function automatic logic [11:0] byp(input logic [9:0] r);
		logic cm;
		cm = (r[9:3] == `RXP_COMMA_POS) || (r[9:3] == `RXP_COMMA_NEG);
		return {~^r, cm, r[1:0], r[9:2]};
	endfunction : byp

	task automatic s_bypass;
		setup(LO, 2'h1, 2'h3, 2'h3, 1'h0);
		bus(1'h1, `RXP_OFF_MASK, 32'h7);
		send(10'h0fd, 8'h0, byp(10'h0fd), 1);
		chk(IRQ_O, 1'h1);
		rchk(`RXP_OFF_STATUS, 32'h3);
		send(10'h2a5, 8'h0, byp(10'h2a5), 1);
		chk(RX_CHAR_CLOCK_OUT_P_O, 1'h0);
		rchk(`RXP_OFF_INFO, {15'h0, 5'h08, byp(10'h2a5)});
		rchk(`RXP_OFF_STATUS, 32'h1);
		repeat (3) @(posedge CORE_CLK_I);
		chk(IRQ_O, 1'h0);
		bus(1'h1, `RXP_OFF_MASK, 32'h0);
		send(10'h300, 8'h0, byp(10'h300), 1);
		chk(IRQ_O, 1'h0);
		rchk(`RXP_OFF_STATUS, 32'h3);
		rchk(8'h10, 32'h0);
		bus(1'h1, 8'h10, 32'h0);
		rchk(`RXP_OFF_CTRL, 32'h1);
	endtask : s_bypass

	task automatic s_decoder;
		logic [11:0] e;
		for (int i = 0; i < 3; i++)
		begin
			setup((i == 1) ? 2'h1 : HI, 2'h3, 2'h1, (i == 0) ? LO : (i == 1) ? 2'h1 : HI, 1'h1);
			e = {1'h1, (i == 2) ? 3'h5 : 3'h2, 8'h5c};
			send(10'h0fd, 8'h5c, e, 1);
			chk(RX_CHAR_CLOCK_OUT_P_O, 1'h1);
			e = {1'h0, (i == 2) ? 3'h5 : 3'h2, 8'h83};
			send(10'h0fd, 8'h83, e, 1);
		end
	endtask : s_decoder

	task automatic s_ref;
		int k;
		logic prev;
		setup(LO, 2'h1, LO, 2'h3, 1'h1);
		chk(RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O, 1'h1);
		k = 0;
		prev = RX_CHAR_CLOCK_OUT_P_O;
		repeat (80)
		begin
			@(posedge CORE_CLK_I);
			if (RX_CHAR_CLOCK_OUT_P_O && !prev)
				k++;
			prev = RX_CHAR_CLOCK_OUT_P_O;
		end
		chk(k, 10);
		send(10'h1e7, 8'h0, byp(10'h1e7), 2);
	endtask : s_ref

	task automatic s_off;
		setup(LO, LO, 2'h3, 2'h3, 1'h0);
		chk(RX_ODD_PARITY_OUT_OE_O, 1'h0);
		chk(RX_DELAYED_REFERENCE_CLOCK_OUT_OE_O, 1'h0);
		REFRAME_ENABLE_I <= 1'h1;
		repeat (6) @(posedge CORE_CLK_I);
		chk(FRAMER_ENABLE_O, 1'h1);
		rchk(`RXP_OFF_STATUS, 32'h4);
		REFRAME_ENABLE_I <= 1'h0;
		bus(1'h1, `RXP_OFF_CTRL, 32'h0);
		repeat (2) @(posedge CORE_CLK_I);
		chk({RX_DATA_OE_O, RX_CHAR_CLOCK_OUT_OE_O}, 2'h0);
	endtask : s_off

	initial
	begin
		s_bypass();
		s_decoder();
		s_ref();
		s_off();
		tally_and_finish();
	end
endmodule : rx_out_port_tb
